// ---- rtl/dtc_defines.vh ----
// Constants for the dual timer/counter block.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
`define DTC_MODE_13BIT 3'h0
`define DTC_MODE_16BIT 3'h1
`define DTC_MODE_RELOAD 3'h2
`define DTC_MODE_SPLIT 3'h3
`define DTC_MODE_PWM 3'h6
`define DTC_PRESCALE_LAST 5'h1f
`define DTC_CNT_RESET 16'h0000
`define DTC_PIN_IDLE 1'h1
`endif

// ---- rtl/dtc_timers.v ----
// Two 16-bit timer/counters with auto-reload, split, PWM and overflow toggle.
`timescale 1ns/1ns
`include "dtc_defines.vh"
// What this block does
// - Timer function counts every machine cycle.
// - Counter function counts count-pin falling edges.
// - Count pin sampled once per cycle.
// - Modes 0, 1, 2, 3, 6 supported.
// - Mode 0: 8-bit counter, divide-by-32 prescaler.
// - Mode 1 uses full 16 bits.
// - Mode 2: 8-bit auto-reload on overflow.
// - Timer 1 mode 3 holds its count.
// - Timer 0 mode 3 splits into two counters.
// - Timer 1 mode 3 feeds baud clock only while its held count is 16'hffff.
// - Mode 6 PWM period is 256 clocks.
// - Toggle output inverts on each overflow.
// - Toggle output shares the count pin.
// - Toggle output high until first overflow.
module dtc_timers (
	input wire i_clk,
	input wire i_rst,
	input wire [2:0] i_t0_mode,
	input wire [2:0] i_t1_mode,
	input wire i_t0_run,
	input wire i_t1_run,
	input wire i_t0h_run,
	input wire i_t0_counter,
	input wire i_t1_counter,
	input wire i_t0_toggle_en,
	input wire i_t1_toggle_en,
	input wire [7:0] i_t0_reload,
	input wire [7:0] i_t1_reload,
	input wire [7:0] i_t0_duty,
	input wire [7:0] i_t1_duty,
	input wire i_t0_load,
	input wire [15:0] i_t0_load_val,
	input wire i_t1_load,
	input wire [15:0] i_t1_load_val,
	input wire i_t0_flag_clr,
	input wire i_t1_flag_clr,
	input wire i_t0h_flag_clr,
	input wire i_first_count_pin_in,
	input wire i_second_count_pin_in,
	output reg o_first_count_pin_out,
	output reg o_first_count_pin_oe_n,
	output reg o_second_count_pin_out,
	output reg o_second_count_pin_oe_n,
	output reg [15:0] o_t0_count,
	output reg [15:0] o_t1_count,
	output reg o_t0_flag,
	output reg o_t1_flag,
	output reg o_t0h_flag,
	output reg o_baud_tick
);

	// Advance one counter by its mode; returns {overflow, next count}.
	function [16:0] dtc_step;
		input [2:0] mode;
		input [15:0] cnt;
		input [7:0] reload;
		reg [16:0] s;
		begin
			s = 17'h00000;
			case (mode)
				`DTC_MODE_13BIT:
				begin
					// Prescaler in the low five bits, counter in the next eight.
					s = {4'h0, cnt[12:0]} + 17'h00001;
					dtc_step = {s[13], cnt[15:13], s[12:0]};
				end
				`DTC_MODE_16BIT:
				begin
					s = {1'h0, cnt} + 17'h00001;
					dtc_step = s;
				end
				`DTC_MODE_RELOAD:
				begin
					// Only the low byte counts; the high byte is left to software.
					if (cnt[7:0] == 8'hff)
						dtc_step = {1'h1, cnt[15:8], reload};
					else
						dtc_step = {1'h0, cnt[15:8], cnt[7:0] + 8'h01};
				end
				`DTC_MODE_PWM:
				begin
					s = {9'h000, cnt[7:0]} + 17'h00001;
					dtc_step = {s[8], cnt[15:8], s[7:0]};
				end
				default:
					dtc_step = {1'h0, cnt};
			endcase
		end
	endfunction

	reg t0_pin_q;
	reg t1_pin_q;
	reg t0_tog_q;
	reg t1_tog_q;
	reg t0_en_q;
	reg t1_en_q;
	reg [16:0] t0_nx;
	reg [16:0] t1_nx;
	reg [8:0] t0h_nx;
	reg t0_tick;
	reg t1_tick;
	reg t0_ov;
	reg t1_ov;
	reg t0h_ov;
	reg t0_pwm;
	reg t1_pwm;

	always @*
	begin
		// One registered sample per cycle; a falling edge is the previous high vs the current low.
		t0_tick = i_t0_counter ? (t0_pin_q & ~i_first_count_pin_in) : 1'h1;
		t1_tick = i_t1_counter ? (t1_pin_q & ~i_second_count_pin_in) : 1'h1;
		t0_nx = {1'h0, o_t0_count};
		t0h_nx = {1'h0, o_t0_count[15:8]};
		t1_nx = {1'h0, o_t1_count};
		if (i_t0_mode == `DTC_MODE_SPLIT)
		begin
			// Split: low byte follows the pin/timer selection, high byte counts cycles.
			if (i_t0_run && t0_tick)
				t0_nx = {o_t0_count[7:0] == 8'hff, o_t0_count[15:8], o_t0_count[7:0] + 8'h01};
			if (i_t0h_run)
				t0h_nx = {1'h0, o_t0_count[15:8]} + 9'h001;
		end
		else if (i_t0_run && t0_tick)
			t0_nx = dtc_step(i_t0_mode, o_t0_count, i_t0_reload);
		if (i_t1_run && t1_tick)
		begin
			// Mode 3 on the second unit keeps the value and makes baud ticks only while that value is 16'hffff.
			if (i_t1_mode == `DTC_MODE_SPLIT)
				t1_nx = {o_t1_count == 16'hffff, o_t1_count};
			else
				t1_nx = dtc_step(i_t1_mode, o_t1_count, i_t1_reload);
		end
		t0_ov = t0_nx[16];
		t1_ov = t1_nx[16];
		t0h_ov = (i_t0_mode == `DTC_MODE_SPLIT) & t0h_nx[8];
		t0_pwm = o_t0_count[7:0] < i_t0_duty;
		t1_pwm = o_t1_count[7:0] < i_t1_duty;
	end

	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			t0_pin_q <= 1'h1;
			t1_pin_q <= 1'h1;
			t0_tog_q <= `DTC_PIN_IDLE;
			t1_tog_q <= `DTC_PIN_IDLE;
			t0_en_q <= 1'h0;
			t1_en_q <= 1'h0;
			o_t0_count <= `DTC_CNT_RESET;
			o_t1_count <= `DTC_CNT_RESET;
			o_t0_flag <= 1'h0;
			o_t1_flag <= 1'h0;
			o_t0h_flag <= 1'h0;
			o_baud_tick <= 1'h0;
			o_first_count_pin_out <= 1'h1;
			o_first_count_pin_oe_n <= 1'h1;
			o_second_count_pin_out <= 1'h1;
			o_second_count_pin_oe_n <= 1'h1;
		end
		else
		begin
			t0_pin_q <= i_first_count_pin_in;
			t1_pin_q <= i_second_count_pin_in;
			t0_en_q <= i_t0_toggle_en;
			t1_en_q <= i_t1_toggle_en;
			if (i_t0_load)
				o_t0_count <= i_t0_load_val;
			else if (i_t0_mode == `DTC_MODE_SPLIT)
				o_t0_count <= {t0h_nx[7:0], t0_nx[7:0]};
			else
				o_t0_count <= t0_nx[15:0];
			if (i_t1_load)
				o_t1_count <= i_t1_load_val;
			else
				o_t1_count <= t1_nx[15:0];
			// A set in the same cycle as a clear wins so no overflow is lost.
			o_t0_flag <= t0_ov | (o_t0_flag & ~i_t0_flag_clr);
			o_t1_flag <= t1_ov | (o_t1_flag & ~i_t1_flag_clr);
			o_t0h_flag <= t0h_ov | (o_t0h_flag & ~i_t0h_flag_clr);
			o_baud_tick <= t1_ov;
			// Enabling the toggle starts from high until the first overflow.
			if (i_t0_toggle_en && !t0_en_q)
				t0_tog_q <= `DTC_PIN_IDLE;
			else if (t0_ov)
				t0_tog_q <= ~t0_tog_q;
			if (i_t1_toggle_en && !t1_en_q)
				t1_tog_q <= `DTC_PIN_IDLE;
			else if (t1_ov)
				t1_tog_q <= ~t1_tog_q;
			// The pin is driven only while toggle or PWM output is in use; counting needs it released.
			o_first_count_pin_oe_n <= ~(i_t0_toggle_en | (i_t0_mode == `DTC_MODE_PWM));
			o_second_count_pin_oe_n <= ~(i_t1_toggle_en | (i_t1_mode == `DTC_MODE_PWM));
			if (i_t0_mode == `DTC_MODE_PWM)
				o_first_count_pin_out <= t0_pwm;
			else if (i_t0_toggle_en && !t0_en_q)
				o_first_count_pin_out <= `DTC_PIN_IDLE;
			else
				o_first_count_pin_out <= t0_ov ? ~t0_tog_q : t0_tog_q;
			if (i_t1_mode == `DTC_MODE_PWM)
				o_second_count_pin_out <= t1_pwm;
			else if (i_t1_toggle_en && !t1_en_q)
				o_second_count_pin_out <= `DTC_PIN_IDLE;
			else
				o_second_count_pin_out <= t1_ov ? ~t1_tog_q : t1_tog_q;
		end
	end

endmodule

// ---- sim/dtc_chk_assertions.sv ----
// Concurrent checks on the timer/counter ports.
`timescale 1ns/1ns
module dtc_chk (
	input wire i_clk,
	input wire i_rst,
	input wire [2:0] i_t0_mode,
	input wire [2:0] i_t1_mode,
	input wire i_t0_run,
	input wire i_t0_counter,
	input wire i_t0_load,
	input wire i_t1_load,
	input wire [7:0] i_t0_reload,
	input wire i_t0_toggle_en,
	input wire i_t1_toggle_en,
	input wire i_t0_flag_clr,
	input wire [15:0] o_t0_count,
	input wire [15:0] o_t1_count,
	input wire o_t0_flag,
	input wire o_first_count_pin_oe_n,
	input wire o_second_count_pin_out
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
wire t = i_t0_run && !i_t0_counter && !i_t0_load;
a_timer_step: assert property (t && i_t0_mode == 3'h1 |=> o_t0_count == $past(o_t0_count) + 16'h1)
	else $error("t0 step");
a_wrap_flag: assert property (t && i_t0_mode == 3'h1 && o_t0_count == 16'hffff |=> o_t0_flag && o_t0_count == 16'h0)
	else $error("t0 wrap");
a_mode0_wrap: assert property (t && i_t0_mode == 3'h0 && o_t0_count[12:0] == 13'h1fff |=> o_t0_flag && o_t0_count[12:0] == 13'h0)
	else $error("mode0 wrap");
a_reload_byte: assert property (t && i_t0_mode == 3'h2 && o_t0_count[7:0] == 8'hff |=> o_t0_count[7:0] == $past(i_t0_reload))
	else $error("reload");
a_t1_hold: assert property (i_t1_mode == 3'h3 && !i_t1_load |=> $stable(o_t1_count))
	else $error("t1 hold");
a_flag_sticky: assert property (o_t0_flag && !i_t0_flag_clr |=> o_t0_flag)
	else $error("flag");
a_toggle_drive: assert property (i_t0_toggle_en |=> !o_first_count_pin_oe_n)
	else $error("pin drive");
a_toggle_high: assert property ($rose(i_t1_toggle_en) |=> o_second_count_pin_out)
	else $error("pin high");
endmodule
bind dtc_timers dtc_chk u_dtc_chk(.*);

// ---- sim/dtc_pin_src.sv ----
// Pulse source standing on the second count pin.
`timescale 1ns/1ns
module dtc_pin_src (
	input wire i_clk,
	input wire i_go,
	output logic o_pin = 1'b1
);
// Every level lasts a whole cycle, so a once-a-cycle sample never misses a pulse.
always @(posedge i_clk) o_pin <= !i_go;
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the timer/counter block.
`timescale 1ns/1ns
module tb;
logic i_clk=0,i_rst=1,i_t0_run=1,i_t1_run=1,i_t0h_run=0,i_t0_counter=0,i_t1_counter=1,go=0,i_t0_toggle_en=0;
logic i_t1_toggle_en=0,i_t0_load=0,i_t1_load=0,i_t0_flag_clr=0,i_t1_flag_clr=0,i_t0h_flag_clr=0;
logic [2:0] i_t0_mode=1,i_t1_mode=1;
logic [7:0] i_t0_reload=0,i_t1_reload=0,i_t0_duty=0,i_t1_duty=0,r;
logic [15:0] i_t0_load_val=0,i_t1_load_val=0;
wire o_first_count_pin_out,o_first_count_pin_oe_n,o_second_count_pin_out,o_second_count_pin_oe_n,src;
wire o_t0_flag,o_t1_flag,o_t0h_flag,o_baud_tick;
wire [15:0] o_t0_count,o_t1_count;
// The first pin idles high through its pull-up; the second is shared with the source.
wire i_first_count_pin_in=o_first_count_pin_oe_n|o_first_count_pin_out;
wire i_second_count_pin_in=o_second_count_pin_oe_n?src:o_second_count_pin_out;
int miscompares=0,checks=0;
int n,h;
always #25 i_clk=~i_clk;
dtc_timers u_dtc_timers(.*);
dtc_pin_src u_dtc_pin_src(.i_clk(i_clk),.i_go(go),.o_pin(src));
task chk(string s,logic [15:0] g,e);
	checks++;
	if (g!==e)
	begin
		miscompares++;
		$display("Error %s expected %h seen %h",s,e,g);
	end
endtask
task cyc(int k);
	repeat (k) @(posedge i_clk);
endtask
task ld0(logic [2:0] m,logic [15:0] v);
	cyc(1);
	{i_t0_mode,i_t0_reload,i_t0_load,i_t0_load_val}<={m,r,1'b1,v};
	{i_t0_duty,i_t1_duty,i_t1_reload,i_t0h_run}<=25'($urandom);
	cyc(1);
	i_t0_load<=0;
endtask
task pls(int k);
	repeat (k)
	begin
		cyc(1);
		go<=1;
		cyc(1);
		go<=0;
	end
	cyc(3);
endtask
function logic [15:0] m0(logic [15:0] v,int k);
	return {v[15:13],13'(v[12:0]+k)};
endfunction
task end_of_test;
	$display("checks %0d miscompares %0d",checks,miscompares);
	if (miscompares==0&&checks>0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
initial
begin
	#100000;
	miscompares++;
	end_of_test;
end
initial
begin
	void'($urandom(32'hea9929e3));
	cyc(3);
	i_rst<=0;
	i_t0_toggle_en<=1;
	r=8'($urandom_range(9));
	ld0(1,16'hffff-r);
	#1 chk("pin",i_first_count_pin_in,1);
	cyc(r+2);
	#1 chk("t0 count",o_t0_count,16'h1);
	chk("t0 flag",o_t0_flag,1);
	chk("pin",i_first_count_pin_in,0);
	cyc(1);
	{i_t0_flag_clr,i_t1_flag_clr,i_t0h_flag_clr}<=3'h7;
	cyc(1);
	{i_t0_flag_clr,i_t1_flag_clr,i_t0h_flag_clr}<=3'h0;
	#1 chk("t0 flag",o_t0_flag,0);
	ld0(0,16'hffff);
	cyc(1);
	#1 chk("mode0",o_t0_count,m0(16'hffff,1));
	chk("pin",i_first_count_pin_in,1);
	r=8'($urandom);
	ld0(2,16'h12fe);
	cyc(2);
	#1 chk("reload",o_t0_count,{8'h12,r});
	$display("unit 0 done");
	r=8'($urandom_range(12,1));
	pls(r);
	#1 chk("t1 events",o_t1_count,16'(r));
	cyc(1);
	i_t1_mode<=3;
	pls(4);
	#1 chk("t1 held",o_t1_count,16'(r));
	cyc(1);
	i_t1_toggle_en<=1;
	cyc(2);
	#1 chk("t1 pin",o_second_count_pin_out,1);
	$display("unit 1 done");
	cyc(1);
	{i_t1_load,i_t1_load_val,i_t1_counter}<={1'b1,16'hffff,1'b0};
	cyc(1);
	i_t1_load<=0;
	cyc(1);
	#1 chk("t1 baud",o_baud_tick,1);
	chk("t1 held",o_t1_count,16'hffff);
	cyc(1);
	{i_t1_mode,i_t1_load,i_t1_load_val}<={3'h1,1'b1,16'hfffe};
	cyc(1);
	i_t1_load<=0;
	cyc(2);
	#1 chk("t1 baud",o_baud_tick,1);
	chk("t1 flag",o_t1_flag,1);
	chk("t1 oe",o_second_count_pin_oe_n,0);
	cyc(1);
	#1 chk("t1 baud",o_baud_tick,0);
	$display("baud done");
	ld0(3,16'hfdfd);
	i_t0h_run<=1;
	cyc(3);
	#1 chk("split",o_t0_count,16'h0000);
	chk("t0h flag",o_t0h_flag,1);
	$display("split done");
	ld0(6,16'h0000);
	i_t0_toggle_en<=0;
	h=0;
	for (n=1;n<=256;n++)
	begin
		cyc(1);
		#1 h=h+o_first_count_pin_out;
		chk("pwm",o_first_count_pin_out,8'(n-1)<i_t0_duty);
	end
	chk("pwm high",16'(h),i_t0_duty);
	chk("pwm oe",o_first_count_pin_oe_n,0);
	$display("pwm done");
	end_of_test;
end
endmodule
